// file: inc/ctb_pkg.sv
// Constants and carrier types for the charger timer and boost configuration block
// What this block does
// - Bit 7 of the timer control register enables charge termination when 1 and resets to 1.
// - The two-bit watchdog field selects off, 40 s, 80 s or 160 s and resets to 01.
// - The timer control register resets to 0x9c, and its reserved bits 6 and 0 reset to 0 but stay read-write.
// - Bit 3 enables the charging safety timer when 1 and resets to 1.
// - The two-bit fast-charge field selects 5, 8, 12 or 20 hours and resets to 10.
// - The boost and thermal control register resets to 0x93 with all eight bits read-write.
// - The boost target is 4.55 V plus the upper-nibble code times 64 mV, up to 5.51 V, resetting to code 1001.
// - The hot cutoff field picks 33, 36 or 30 percent of the internal rail for codes 00, 01, 10 and resets to 00.
// - Hot cutoff code 11 runs boost unmonitored while the thermistor fault still uses 33 percent.
// - The die temperature field selects 60, 80, 100 or 120 degrees C and resets to 11.
// - Expiry of the watchdog period sets a read-only watchdog fault flag.
// - With slow-down set, the safety timer runs at half rate during input limiting or thermal regulation.
package ctb_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_MS = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SEC_PER_HOUR = 3600;
  localparam logic [7:0] WD_PERIOD_0_S = 8'h28;
  localparam logic [7:0] WD_PERIOD_1_S = 8'h50;
  localparam logic [7:0] WD_PERIOD_2_S = 8'ha0;
  localparam int FC_LIMIT_0_H = 5;
  localparam int FC_LIMIT_1_H = 8;
  localparam int FC_LIMIT_2_H = 12;
  localparam int FC_LIMIT_3_H = 20;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] TMR_CTRL_OFS = 8'h05;
  localparam logic [7:0] BOOST_CTRL_OFS = 8'h06;
  localparam logic [7:0] TMR_CTRL_RST = 8'h9c;
  localparam logic [7:0] BOOST_CTRL_RST = 8'h93;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  localparam int TERM_EN_POS = 7;
  localparam int WD_SEL_POS = 4;
  localparam int TMR_EN_POS = 3;
  localparam int FC_SEL_POS = 1;
  localparam int BOOST_LVL_POS = 4;
  localparam int HOT_SEL_POS = 2;
  localparam int DIE_SEL_POS = 0;

  // ------------------------------------------------------------
  // Encodings and thresholds
  // ------------------------------------------------------------
  localparam logic [1:0] WD_OFF = 2'b00;
  localparam logic [1:0] HOT_NO_MON = 2'b11;
  localparam int BOOST_BASE_MV = 4550;
  localparam int BOOST_STEP_MV = 64;
  localparam logic [6:0] HOT_PCT_0 = 7'h21;
  localparam logic [6:0] HOT_PCT_1 = 7'h24;
  localparam logic [6:0] HOT_PCT_2 = 7'h1e;
  localparam logic [6:0] DIE_C_0 = 7'h3c;
  localparam logic [6:0] DIE_C_1 = 7'h50;
  localparam logic [6:0] DIE_C_2 = 7'h64;
  localparam logic [6:0] DIE_C_3 = 7'h78;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic termEn;
    logic rsvdHi;
    logic [1:0] wdSel;
    logic safetyEn;
    logic [1:0] fast_charge_limit_sel;
    logic rsvdLo;
  } ctb_tmr_ctrl_t;

  typedef struct packed {
    logic [3:0] boost_out_level;
    logic [1:0] hotCutSel;
    logic [1:0] die_temp_limit_sel;
  } ctb_boost_ctrl_t;

  typedef enum logic [3:0] {
    I2C_IDLE = 4'b0000,
    I2C_ADDR = 4'b0001,
    I2C_AACK = 4'b0011,
    I2C_PTR = 4'b0010,
    I2C_PACK = 4'b0110,
    I2C_WDAT = 4'b0111,
    I2C_WACK = 4'b0101,
    I2C_RDAT = 4'b0100,
    I2C_RACK = 4'b1100
  } ctb_i2c_st_t;

endpackage

// file: rtl/ctb_cfg_regs.sv
// Serial management target and timer/boost configuration registers
`timescale 1ns/10ps
module ctb_cfg_regs #(
  parameter int TICK_CYCLES = ctb_pkg::TICK_CYCLES,
  // Bus address value is arbitrary
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic chargeActive,
  input wire logic inDpmActive,
  input wire logic thermRegActive,
  input wire logic safety_timer_slowdown,
  input wire logic wdFaultClr,
  output ctb_pkg::ctb_tmr_ctrl_t tmrCtrl,
  output ctb_pkg::ctb_boost_ctrl_t boostCtrl,
  output logic [12:0] boostOutMv,
  output logic [6:0] hotCutPct,
  output logic hotMonEn,
  output logic [6:0] thermistorFaultPct,
  output logic [6:0] dieTempLimitC,
  output logic hostWrite,
  output logic watchdogFault,
  output logic safetyExpired
);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  // ------------------------------------------------------------
  // Read decode
  // ------------------------------------------------------------
  function automatic logic [7:0] regRead(
    input logic [7:0] ofs,
    input logic [7:0] tmrVal,
    input logic [7:0] boostVal
  );
    logic [7:0] val;
    val = ctb_pkg::UNMAPPED_RD;
    if (ofs == ctb_pkg::TMR_CTRL_OFS) begin
      val = tmrVal;
    end else if (ofs == ctb_pkg::BOOST_CTRL_OFS) begin
      val = boostVal;
    end
    return val;
  endfunction

  ctb_pkg::ctb_i2c_st_t state_ff;
  ctb_pkg::ctb_tmr_ctrl_t tmrCtrl_ff;
  ctb_pkg::ctb_boost_ctrl_t boostCtrl_ff;
  logic sclD_ff;
  logic sdaD_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] ptr_ff;
  logic [7:0] txByte_ff;
  logic rdMode_ff;
  logic mstNack_ff;
  logic sdaOe_ff;
  logic sdaOut_ff;
  logic hostWrite_ff;
  logic [12:0] boostOutMv_ff;
  logic [6:0] hotCutPct_ff;
  logic hotMonEn_ff;
  logic [6:0] ntcPct_ff;
  logic [6:0] dieTempC_ff;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic byteDone;
  logic wrEn;
  logic [7:0] rdCur;
  logic [7:0] rdNext;
  logic [2:0] txIdx;

  // ------------------------------------------------------------
  // Line sampling and bus conditions
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclD_ff <= 1'b1;
      sdaD_ff <= 1'b1;
    end else begin
      sclD_ff <= sclIn;
      sdaD_ff <= sdaIn;
    end
  end

  assign sclRise = sclIn && !sclD_ff;
  assign sclFall = !sclIn && sclD_ff;
  assign startCond = sclIn && sclD_ff && sdaD_ff && !sdaIn;
  assign stopCond = sclIn && sclD_ff && !sdaD_ff && sdaIn;
  assign byteDone = (bitCnt_ff == 4'h8);
  assign wrEn = sclFall && (state_ff == ctb_pkg::I2C_WDAT) && byteDone;
  assign rdCur = regRead(ptr_ff, tmrCtrl_ff, boostCtrl_ff);
  assign rdNext = regRead(ptr_ff + 8'h01, tmrCtrl_ff, boostCtrl_ff);
  assign txIdx = 3'(4'h7 - bitCnt_ff);

  // ------------------------------------------------------------
  // Protocol engine
  // ------------------------------------------------------------
  // Open drain: only ever pulls low, so the driven level is a constant
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sdaOut_ff <= 1'b0;
    end else begin
      sdaOut_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ctb_pkg::I2C_IDLE;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      txByte_ff <= 8'h00;
      rdMode_ff <= 1'b0;
      mstNack_ff <= 1'b0;
      sdaOe_ff <= 1'b0;
    end else if (startCond) begin
      // Repeated start keeps the pointer
      state_ff <= ctb_pkg::I2C_ADDR;
      bitCnt_ff <= 4'h0;
      sdaOe_ff <= 1'b0;
    end else if (stopCond) begin
      state_ff <= ctb_pkg::I2C_IDLE;
      sdaOe_ff <= 1'b0;
    end else if (sclRise) begin
      case (state_ff)
        ctb_pkg::I2C_ADDR, ctb_pkg::I2C_PTR, ctb_pkg::I2C_WDAT: begin
          shift_ff <= {shift_ff[6:0], sdaIn};
          bitCnt_ff <= bitCnt_ff + 4'h1;
        end
        ctb_pkg::I2C_RDAT: begin
          bitCnt_ff <= bitCnt_ff + 4'h1;
        end
        ctb_pkg::I2C_RACK: begin
          mstNack_ff <= sdaIn;
        end
        default: begin
        end
      endcase
    end else if (sclFall) begin
      case (state_ff)
        ctb_pkg::I2C_ADDR: begin
          if (byteDone && shift_ff[7:1] == DEV_ADDR) begin
            state_ff <= ctb_pkg::I2C_AACK;
            rdMode_ff <= shift_ff[0];
            sdaOe_ff <= 1'b1;
          end else if (byteDone) begin
            state_ff <= ctb_pkg::I2C_IDLE;
          end
        end
        ctb_pkg::I2C_AACK: begin
          bitCnt_ff <= 4'h0;
          if (rdMode_ff) begin
            state_ff <= ctb_pkg::I2C_RDAT;
            txByte_ff <= rdCur;
            sdaOe_ff <= !rdCur[7];
          end else begin
            state_ff <= ctb_pkg::I2C_PTR;
            sdaOe_ff <= 1'b0;
          end
        end
        ctb_pkg::I2C_PTR: begin
          if (byteDone) begin
            state_ff <= ctb_pkg::I2C_PACK;
            ptr_ff <= shift_ff;
            sdaOe_ff <= 1'b1;
          end
        end
        ctb_pkg::I2C_PACK: begin
          state_ff <= ctb_pkg::I2C_WDAT;
          bitCnt_ff <= 4'h0;
          sdaOe_ff <= 1'b0;
        end
        ctb_pkg::I2C_WDAT: begin
          if (byteDone) begin
            state_ff <= ctb_pkg::I2C_WACK;
            ptr_ff <= ptr_ff + 8'h01;
            sdaOe_ff <= 1'b1;
          end
        end
        ctb_pkg::I2C_WACK: begin
          state_ff <= ctb_pkg::I2C_WDAT;
          bitCnt_ff <= 4'h0;
          sdaOe_ff <= 1'b0;
        end
        ctb_pkg::I2C_RDAT: begin
          if (byteDone) begin
            state_ff <= ctb_pkg::I2C_RACK;
            sdaOe_ff <= 1'b0;
          end else begin
            sdaOe_ff <= !txByte_ff[txIdx];
          end
        end
        ctb_pkg::I2C_RACK: begin
          if (mstNack_ff) begin
            state_ff <= ctb_pkg::I2C_IDLE;
            sdaOe_ff <= 1'b0;
          end else begin
            state_ff <= ctb_pkg::I2C_RDAT;
            bitCnt_ff <= 4'h0;
            ptr_ff <= ptr_ff + 8'h01;
            txByte_ff <= rdNext;
            sdaOe_ff <= !rdNext[7];
          end
        end
        default: begin
          state_ff <= ctb_pkg::I2C_IDLE;
          sdaOe_ff <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // Reserved bits are stored like any other; unmapped writes are dropped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tmrCtrl_ff <= ctb_pkg::ctb_tmr_ctrl_t'(ctb_pkg::TMR_CTRL_RST);
    end else if (wrEn && ptr_ff == ctb_pkg::TMR_CTRL_OFS) begin
      tmrCtrl_ff <= ctb_pkg::ctb_tmr_ctrl_t'(shift_ff);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boostCtrl_ff <= ctb_pkg::ctb_boost_ctrl_t'(ctb_pkg::BOOST_CTRL_RST);
    end else if (wrEn && ptr_ff == ctb_pkg::BOOST_CTRL_OFS) begin
      boostCtrl_ff <= ctb_pkg::ctb_boost_ctrl_t'(shift_ff);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hostWrite_ff <= 1'b0;
    end else begin
      hostWrite_ff <= wrEn;
    end
  end

  // ------------------------------------------------------------
  // Threshold decode for the analog loops
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boostOutMv_ff <= 13'h0;
    end else begin
      boostOutMv_ff <= 13'(ctb_pkg::BOOST_BASE_MV
        + int'(boostCtrl_ff.boost_out_level) * ctb_pkg::BOOST_STEP_MV);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hotCutPct_ff <= 7'h0;
      hotMonEn_ff <= 1'b0;
      ntcPct_ff <= 7'h0;
    end else begin
      case (boostCtrl_ff.hotCutSel)
        2'b00: hotCutPct_ff <= ctb_pkg::HOT_PCT_0;
        2'b01: hotCutPct_ff <= ctb_pkg::HOT_PCT_1;
        2'b10: hotCutPct_ff <= ctb_pkg::HOT_PCT_2;
        default: hotCutPct_ff <= ctb_pkg::HOT_PCT_0;
      endcase
      // Fault reporting keeps working even with the cutoff disabled
      hotMonEn_ff <= (boostCtrl_ff.hotCutSel != ctb_pkg::HOT_NO_MON);
      if (boostCtrl_ff.hotCutSel == ctb_pkg::HOT_NO_MON) begin
        ntcPct_ff <= ctb_pkg::HOT_PCT_0;
      end else begin
        ntcPct_ff <= (boostCtrl_ff.hotCutSel == 2'b01) ? ctb_pkg::HOT_PCT_1
          : (boostCtrl_ff.hotCutSel == 2'b10) ? ctb_pkg::HOT_PCT_2 : ctb_pkg::HOT_PCT_0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dieTempC_ff <= 7'h0;
    end else begin
      case (boostCtrl_ff.die_temp_limit_sel)
        2'b00: dieTempC_ff <= ctb_pkg::DIE_C_0;
        2'b01: dieTempC_ff <= ctb_pkg::DIE_C_1;
        2'b10: dieTempC_ff <= ctb_pkg::DIE_C_2;
        default: dieTempC_ff <= ctb_pkg::DIE_C_3;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Timers
  // ------------------------------------------------------------
  ctb_watchdog #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_watchdog (
    .ref_clk(ref_clk),
    .rst(rst),
    .wdSel(tmrCtrl_ff.wdSel),
    .hostWrite(hostWrite_ff),
    .faultClr(wdFaultClr),
    .wdFault(watchdogFault)
  );

  ctb_safety_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_safety (
    .ref_clk(ref_clk),
    .rst(rst),
    .timerEn(tmrCtrl_ff.safetyEn),
    .limitSel(tmrCtrl_ff.fast_charge_limit_sel),
    .chargeActive(chargeActive),
    .slowDown(safety_timer_slowdown && (inDpmActive || thermRegActive)),
    .expired(safetyExpired)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign sdaOut = sdaOut_ff;
  assign sdaOe = sdaOe_ff;
  assign tmrCtrl = tmrCtrl_ff;
  assign boostCtrl = boostCtrl_ff;
  assign boostOutMv = boostOutMv_ff;
  assign hotCutPct = hotCutPct_ff;
  assign hotMonEn = hotMonEn_ff;
  assign thermistorFaultPct = ntcPct_ff;
  assign dieTempLimitC = dieTempC_ff;
  assign hostWrite = hostWrite_ff;

endmodule

// file: rtl/ctb_safety_timer.sv
// Fast-charge safety timer with half-rate slow-down
`timescale 1ns/10ps
module ctb_safety_timer #(
  parameter int TICK_CYCLES = ctb_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic timerEn,
  input wire logic [1:0] limitSel,
  input wire logic chargeActive,
  input wire logic slowDown,
  output logic expired
);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  logic [31:0] preCnt_ff;
  logic [16:0] secCnt_ff;
  logic halfPhase_ff;
  logic expired_ff;
  logic [16:0] limitS;
  logic tick;
  logic advance;

  always_comb begin
    case (limitSel)
      2'b00: limitS = 17'(ctb_pkg::FC_LIMIT_0_H * ctb_pkg::SEC_PER_HOUR);
      2'b01: limitS = 17'(ctb_pkg::FC_LIMIT_1_H * ctb_pkg::SEC_PER_HOUR);
      2'b10: limitS = 17'(ctb_pkg::FC_LIMIT_2_H * ctb_pkg::SEC_PER_HOUR);
      default: limitS = 17'(ctb_pkg::FC_LIMIT_3_H * ctb_pkg::SEC_PER_HOUR);
    endcase
  end

  assign tick = (preCnt_ff == 32'(TICK_CYCLES - 1));
  // Half rate drops every other second tick
  assign advance = tick && (!slowDown || halfPhase_ff);

  // ------------------------------------------------------------
  // Counting only while enabled and charging
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      preCnt_ff <= 32'h0;
      secCnt_ff <= 17'h0;
      halfPhase_ff <= 1'b0;
    end else if (!timerEn || !chargeActive || expired_ff) begin
      preCnt_ff <= 32'h0;
      secCnt_ff <= 17'h0;
      halfPhase_ff <= 1'b0;
    end else if (tick) begin
      preCnt_ff <= 32'h0;
      halfPhase_ff <= !halfPhase_ff;
      if (advance) begin
        secCnt_ff <= secCnt_ff + 17'h1;
      end
    end else begin
      preCnt_ff <= preCnt_ff + 32'h1;
    end
  end

  // Held until the charge cycle ends or the timer is disabled
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      expired_ff <= 1'b0;
    end else if (!timerEn || !chargeActive) begin
      expired_ff <= 1'b0;
    end else if (secCnt_ff >= limitS) begin
      expired_ff <= 1'b1;
    end
  end

  assign expired = expired_ff;

endmodule

// file: rtl/ctb_watchdog.sv
// Host-link watchdog with sticky expiry flag
`timescale 1ns/10ps
module ctb_watchdog #(
  parameter int TICK_CYCLES = ctb_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] wdSel,
  input wire logic hostWrite,
  input wire logic faultClr,
  output logic wdFault
);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  logic [31:0] preCnt_ff;
  logic [7:0] secCnt_ff;
  logic [7:0] limitS;
  logic tick;
  logic expire;
  logic wdFault_ff;

  always_comb begin
    case (wdSel)
      2'b01: limitS = ctb_pkg::WD_PERIOD_0_S;
      2'b10: limitS = ctb_pkg::WD_PERIOD_1_S;
      2'b11: limitS = ctb_pkg::WD_PERIOD_2_S;
      default: limitS = 8'h00;
    endcase
  end

  assign tick = (preCnt_ff == 32'(TICK_CYCLES - 1));
  assign expire = tick && (secCnt_ff == limitS - 8'h01) && (wdSel != ctb_pkg::WD_OFF);

  // ------------------------------------------------------------
  // Counting; any valid write starts a fresh period
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      preCnt_ff <= 32'h0;
      secCnt_ff <= 8'h00;
    end else if (hostWrite || wdSel == ctb_pkg::WD_OFF || expire) begin
      preCnt_ff <= 32'h0;
      secCnt_ff <= 8'h00;
    end else if (tick) begin
      preCnt_ff <= 32'h0;
      secCnt_ff <= secCnt_ff + 8'h01;
    end else begin
      preCnt_ff <= preCnt_ff + 32'h1;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdFault_ff <= 1'b0;
    end else if (expire) begin
      wdFault_ff <= 1'b1;
    end else if (faultClr) begin
      wdFault_ff <= 1'b0;
    end
  end

  assign wdFault = wdFault_ff;

endmodule

// file: sim/ctb_cfg_regs_sva.sv
// Concurrent checks for the timer and boost configuration registers
`timescale 1ns/10ps
module ctb_cfg_regs_sva #(
  parameter int TICK_CYCLES = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wdFaultClr,
  input wire ctb_pkg::ctb_tmr_ctrl_t tmrCtrl,
  input wire ctb_pkg::ctb_boost_ctrl_t boostCtrl,
  input wire logic [12:0] boostOutMv,
  input wire logic [6:0] hotCutPct,
  input wire logic hotMonEn,
  input wire logic [6:0] thermistorFaultPct,
  input wire logic [6:0] dieTempLimitC,
  input wire logic hostWrite,
  input wire logic watchdogFault
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Code 11 falls back to the 33 percent level
  function automatic logic [6:0] hotPct(input logic [1:0] s);
    return s == 2'h1 ? 7'h24 : (s == 2'h2 ? 7'h1e : 7'h21);
  endfunction

  a_tmr_reset_val: assert property ($fell(rst) |-> tmrCtrl == 8'h9c)
    else $error("timer control not at reset value");
  a_boost_reset_val: assert property ($fell(rst) |-> boostCtrl == 8'h93)
    else $error("boost control not at reset value");
  a_boost_level_mv: assert property (!$past(rst) |-> boostOutMv == 13'h11c6 + 13'h40 * $past(boostCtrl[7:4]))
    else $error("boost target wrong");
  a_hot_cut_pct: assert property (!$past(rst) |-> hotCutPct == hotPct($past(boostCtrl.hotCutSel)))
    else $error("hot cutoff level wrong");
  a_fault_pct_level: assert property (!$past(rst) |-> thermistorFaultPct == hotPct($past(boostCtrl.hotCutSel)))
    else $error("thermistor fault level wrong");
  a_hot_monitor_en: assert property (!$past(rst) |-> hotMonEn == ($past(boostCtrl.hotCutSel) != 2'h3))
    else $error("hot monitor enable wrong");
  a_die_temp_limit: assert property (!$past(rst) |-> dieTempLimitC == 7'h3c + 7'h14 * $past(boostCtrl[1:0]))
    else $error("die limit wrong");
  a_wd_off_quiet: assert property ($rose(watchdogFault) |-> $past(tmrCtrl.wdSel) != 2'h0)
    else $error("fault with watchdog off");
  a_wd_fault_sticky: assert property (watchdogFault && !wdFaultClr |=> watchdogFault)
    else $error("watchdog fault dropped");
  a_wd_write_restart: assert property (hostWrite |-> ##2 (!$rose(watchdogFault)) [*8])
    else $error("fault right after host write");
  a_write_pulse_once: assert property (hostWrite |=> !hostWrite)
    else $error("host write pulse too long");
  a_reg_needs_write: assert property (!$past(rst) && ($changed(tmrCtrl) || $changed(boostCtrl)) |-> hostWrite)
    else $error("register changed without write");

  c_host_write: cover property (hostWrite);
  c_wd_expiry: cover property ($rose(watchdogFault));
  c_hot_unmonitored: cover property (!hotMonEn);
endmodule

// file: sim/ctb_host_model.sv
// Serial management host model driving the configuration target
`timescale 1ns/10ps
module ctb_host_model (
  input wire logic ref_clk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaLow
);
  // Quarter bit period in ref_clk cycles; raise it to act as a slow host
  int halfCyc = 3;

  initial begin
    scl = 1'h1;
    sdaLow = 1'h0;
  end

  task automatic hp();
    repeat (halfCyc) @(posedge ref_clk);
    #5;
  endtask

  // Also serves as repeated start, data moves only while clock low
  task automatic start();
    sdaLow = 1'h0;
    hp();
    scl = 1'h1;
    hp();
    sdaLow = 1'h1;
    hp();
    scl = 1'h0;
    hp();
  endtask

  task automatic stop();
    sdaLow = 1'h1;
    hp();
    scl = 1'h1;
    hp();
    sdaLow = 1'h0;
    hp();
  endtask

  task automatic bitx(input logic b, output logic q);
    sdaLow = !b;
    hp();
    scl = 1'h1;
    hp();
    q = sdaLine;
    hp();
    scl = 1'h0;
    hp();
  endtask

  // Eight bits MSB first, then the ninth bit; each written data byte restarts the watchdog
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(last, ack);
  endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the timer and boost configuration registers
`timescale 1ns/10ps
module tb_top;
  localparam int TICKS = 2;
  // Bus address value is arbitrary
  localparam logic [6:0] DEV = 7'h2a;
  logic refClk = 1'h0;
  logic rst, chargeActive, inDpm, thermReg, slowDown, wdClr, hostLow, dutOut, dutOe, scl, sda, a;
  ctb_pkg::ctb_tmr_ctrl_t tmrCtrl;
  ctb_pkg::ctb_boost_ctrl_t boostCtrl;
  logic [12:0] boostMv;
  logic [6:0] hotPct, faultPct, dieC;
  logic hotMon, hostWrite, wdFault, safeExp;
  logic [7:0] v, r;
  logic [6:0] pctTab [4] = '{7'h21, 7'h24, 7'h1e, 7'h21};
  int n_errors = 0;
  int checks = 0;
  int cycleCount = 0;

  always #50 refClk = ~refClk;
  // Open-drain data wire with pull-up
  assign sda = !(hostLow || dutOe);

  ctb_host_model host (.ref_clk(refClk), .sdaLine(sda), .scl(scl), .sdaLow(hostLow));
  ctb_cfg_regs #(.TICK_CYCLES(TICKS), .DEV_ADDR(DEV)) dut (
    .ref_clk(refClk), .rst(rst), .sclIn(scl), .sdaIn(sda), .sdaOut(dutOut), .sdaOe(dutOe),
    .chargeActive(chargeActive), .inDpmActive(inDpm), .thermRegActive(thermReg),
    .safety_timer_slowdown(slowDown), .wdFaultClr(wdClr), .tmrCtrl(tmrCtrl), .boostCtrl(boostCtrl),
    .boostOutMv(boostMv), .hotCutPct(hotPct), .hotMonEn(hotMon), .thermistorFaultPct(faultPct),
    .dieTempLimitC(dieC), .hostWrite(hostWrite), .watchdogFault(wdFault), .safetyExpired(safeExp));

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge refClk);
    #5;
  endtask

  task automatic wrReg(input logic [7:0] ofs, input logic [7:0] val);
    logic [7:0] q;
    logic a0, a1, a2;
    host.start();
    host.xfer({DEV, 1'h0}, 1'h1, q, a0);
    host.xfer(ofs, 1'h1, q, a1);
    host.xfer(val, 1'h1, q, a2);
    host.stop();
    chk({a0, a1, a2}, 3'h0, "write ack");
  endtask

  task automatic rdReg(input logic [7:0] ofs, output logic [7:0] val);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    host.start();
    host.xfer({DEV, 1'h0}, 1'h1, q, a0);
    host.xfer(ofs, 1'h1, q, a1);
    host.start();
    host.xfer({DEV, 1'h1}, 1'h1, q, a2);
    host.xfer(8'hff, 1'h1, val, a3);
    host.stop();
    chk({a0, a1, a2}, 3'h0, "read ack");
  endtask

  task automatic results();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run is near 83000 cycles
  always @(posedge refClk) begin
    cycleCount++;
    if (cycleCount == 95000) begin
      n_errors++;
      $display("mismatch at %0t: timeout", $time);
      results();
    end
  end

  // ----
  // Sequence
  // ----
  initial begin
    rst = 1'h1;
    chargeActive = 1'h0;
    inDpm = 1'h0;
    thermReg = 1'h0;
    slowDown = 1'h0;
    wdClr = 1'h0;
    cyc(5);
    rst = 1'h0;
    cyc(3);
    chk(tmrCtrl, 8'h9c, "timer reset");
    chk(tmrCtrl.termEn, 1'h1, "term reset");
    chk(tmrCtrl.wdSel, 2'h1, "wd reset");
    chk(tmrCtrl.safetyEn, 1'h1, "safety reset");
    chk(tmrCtrl.fast_charge_limit_sel, 2'h2, "limit reset");
    chk(boostMv, 13'h1406, "boost reset");
    chk(hotPct, 7'h21, "hot reset");
    chk(dieC, 7'h78, "die reset");
    chk(dutOut, 1'h0, "drive level");
    rdReg(8'h05, r);
    chk(r, 8'h9c, "read timer");
    rdReg(8'h06, r);
    chk(r, 8'h93, "read boost");
    host.halfCyc = 5;
    wrReg(8'h05, 8'h41);
    host.halfCyc = 3;
    rdReg(8'h05, r);
    chk(r, 8'h41, "reserved bits");
    chk(tmrCtrl.termEn, 1'h0, "term off");
    rst = 1'h1;
    cyc(2);
    rst = 1'h0;
    cyc(2);
    chk(tmrCtrl, 8'h9c, "second reset");
    for (int c = 0; c < 16; c++) begin
      v = {4'(c), 2'(c), 2'(c >> 2)};
      wrReg(8'h06, v);
      cyc(2);
      chk(boostCtrl, v, "boost reg");
      chk(boostMv, 13'h11c6 + 13'h40 * 13'(c), "boost mv");
      chk(hotMon, v[3:2] != 2'h3, "hot mon");
      chk(hotPct, pctTab[v[3:2]], "hot pct");
      chk(faultPct, pctTab[v[3:2]], "fault pct");
      chk(dieC, 7'h3c + 7'h14 * v[1:0], "die limit");
    end
    // Unmapped place is acknowledged but holds nothing
    wrReg(8'h0a, 8'h5a);
    rdReg(8'h0a, r);
    chk(r, 8'h00, "unmapped read");
    chk({tmrCtrl, boostCtrl}, 16'h9cff, "unmapped write");
    host.start();
    host.xfer({DEV ^ 7'h01, 1'h0}, 1'h1, r, a);
    host.stop();
    chk(a, 1'h1, "foreign address");
    for (int s = 0; s < 4; s++) begin
      wrReg(8'h05, {2'h2, 2'(s), 4'hc});
      wdClr = 1'h1;
      cyc(1);
      wdClr = 1'h0;
      cyc(20 << s);
      chk(wdFault, 1'h0, "wd early");
      cyc(20 << s);
      chk(wdFault, s != 0, "wd expiry");
    end
    // Slowed timer must outlast the plain 5 hour count
    wrReg(8'h05, 8'h88);
    slowDown = 1'h1;
    inDpm = 1'h1;
    chargeActive = 1'h1;
    cyc(60000);
    chk(safeExp, 1'h0, "half rate");
    inDpm = 1'h0;
    thermReg = 1'h1;
    cyc(12500);
    chk(safeExp, 1'h1, "limit expiry");
    chargeActive = 1'h0;
    cyc(3);
    chk(safeExp, 1'h0, "charge stop");
    results();
  end
endmodule

bind ctb_cfg_regs ctb_cfg_regs_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .ref_clk, .rst, .wdFaultClr, .tmrCtrl, .boostCtrl, .boostOutMv, .hotCutPct, .hotMonEn,
  .thermistorFaultPct, .dieTempLimitC, .hostWrite, .watchdogFault);
